// file: inc/dcfpf_regs.vh
`ifndef DCFPF_REGS_VH
`define DCFPF_REGS_VH

// Storage shape: 65536 x 16 fills one megabit
`define DCFPF_WIDTH 16
`define DCFPF_DEPTH 65536
`define DCFPF_ADDR_W 16

// Write staging buffer in front of the main array
`define DCFPF_STAGE_DEPTH 16
`define DCFPF_STAGE_ADDR_W 4

// Default offset pairs, index {offset_load, select1, select0}
`define DCFPF_DEF_OFFS_0 16'h0007
`define DCFPF_DEF_OFFS_1 16'h000F
`define DCFPF_DEF_OFFS_2 16'h001F
`define DCFPF_DEF_OFFS_3 16'h003F
`define DCFPF_DEF_OFFS_4 16'h007F
`define DCFPF_DEF_OFFS_5 16'h00FF
`define DCFPF_DEF_OFFS_6 16'h01FF
`define DCFPF_DEF_OFFS_7 16'h03FF

// Flag timing mode values
`define DCFPF_MODE_ASYNC 1'b0
`define DCFPF_MODE_SYNC 1'b1

`endif

// file: rtl/dcfpf_stage_fifo.v
`timescale 1ns/1ps
module dcfpf_stage_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire clk_i,
  input wire rst_i,
  input wire clr_i,
  input wire in_valid_i,
  output wire in_ready_o,
  input wire [WIDTH-1:0] in_data_i,
  output wire out_valid_o,
  input wire out_ready_i,
  output wire [WIDTH-1:0] out_data_o,
  output wire [AW:0] count_o
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0] wr_ptr_r;
  reg [AW:0] rd_ptr_r;
  wire push;
  wire pop;

  assign count_o = wr_ptr_r - rd_ptr_r;
  assign in_ready_o = (count_o != DEPTH[AW:0]);
  assign out_valid_o = (count_o != {(AW+1){1'b0}});
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;
  assign out_data_o = mem[rd_ptr_r[AW-1:0]];

  always @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr_r[AW-1:0]] <= in_data_i;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i | clr_i) begin
      wr_ptr_r <= {(AW+1){1'b0}};
      rd_ptr_r <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
    end
  end

endmodule // dcfpf_stage_fifo

// file: rtl/dcfpf_top.v
// Functional notes
// - Write and read clocks are fully independent, any ratio or phase.
// - Words written on write clock leave in order on read clock.
// - Depth and width are build parameters, up to one megabit.
// - Five active-low flags: empty, full, half, almost-empty, almost-full.
// - Almost thresholds set separately, measured from empty or full.
// - Eight default offset pairs picked by select and load pins.
// - Serial enable with offset load shifts one bit per write edge.
// - Full reset clears pointers, reloads offsets and flag timing mode.
// - Pointer-only reset clears pointers, keeps offsets and mode.
// - Async mode: almost-empty falls on read edge, rises on write edge.
// - Async mode: almost-full falls on write edge, rises on read edge.
// - Sync mode: almost-empty changes only on read clock edges.
// - Sync mode: almost-full changes only on write clock edges.
// - Flag timing mode is captured from its pin during full reset.
// - Idle state entered automatically, left at once on any control.
// - Half-full asserts when stored count reaches depth/2 plus one.
//
`timescale 1ns/1ps
`include "dcfpf_regs.vh"
module dcfpf_top #(
  parameter WIDTH = `DCFPF_WIDTH,
  parameter DEPTH = `DCFPF_DEPTH,
  parameter AW = `DCFPF_ADDR_W
) (
  input wire CLK_I,
  input wire SRST_I,
  input wire WRITE_CLK_I,
  input wire READ_CLK_I,
  input wire WRITE_EN_N_I,
  input wire READ_EN_N_I,
  input wire [WIDTH-1:0] WRITE_DATA_IN_I,
  output wire [WIDTH-1:0] READ_DATA_OUT_O,
  input wire FULL_RESET_N_I,
  input wire POINTER_ONLY_RESET_N_I,
  input wire DEFAULT_OFFSET_SELECT0_I,
  input wire DEFAULT_OFFSET_SELECT1_I,
  input wire OFFSET_LOAD_N_I,
  input wire SERIAL_SHIFT_ENABLE_N_I,
  input wire SERIAL_IN_I,
  input wire FLAG_TIMING_MODE_SELECT_I,
  output wire EMPTY_FLAG_N_O,
  output wire FULL_FLAG_N_O,
  output wire HALF_FULL_FLAG_N_O,
  output wire ALMOST_EMPTY_FLAG_N_O,
  output wire ALMOST_FULL_FLAG_N_O,
  output wire IDLE_O
);

  localparam SAW = `DCFPF_STAGE_ADDR_W;
  localparam NPIN = WIDTH + 11;
  localparam HALF_I = DEPTH / 2 + 1;
  localparam [AW+1:0] DEPTH_W = DEPTH[AW+1:0];
  localparam [AW+1:0] HALF_W = HALF_I[AW+1:0];
  // Sampler reset value: clocks low, active-low controls inactive
  localparam [NPIN-1:0] PIN_IDLE = {2'h0, 4'hF, 2'h0, 2'h3, 1'h0,
                                    {WIDTH{1'h0}}};

  function [AW:0] bin2gray;
    input [AW:0] b;
    begin
      bin2gray = b ^ (b >> 1);
    end
  endfunction

  function [AW:0] gray2bin;
    input [AW:0] g;
    integer k;
    begin
      gray2bin[AW] = g[AW];
      for (k = AW - 1; k >= 0; k = k - 1) begin
        gray2bin[k] = gray2bin[k+1] ^ g[k];
      end
    end
  endfunction

  function [AW-1:0] default_offset;
    input [2:0] idx;
    reg [15:0] v;
    begin
      case (idx)
        3'h0: v = `DCFPF_DEF_OFFS_0;
        3'h1: v = `DCFPF_DEF_OFFS_1;
        3'h2: v = `DCFPF_DEF_OFFS_2;
        3'h3: v = `DCFPF_DEF_OFFS_3;
        3'h4: v = `DCFPF_DEF_OFFS_4;
        3'h5: v = `DCFPF_DEF_OFFS_5;
        3'h6: v = `DCFPF_DEF_OFFS_6;
        default: v = `DCFPF_DEF_OFFS_7;
      endcase
      // Shallow builds keep only the low pointer bits
      default_offset = v[AW-1:0];
    end
  endfunction

  // Two-stage sampling of every pin
  wire [NPIN-1:0] pin_raw;
  reg [NPIN-1:0] pin_s1_r;
  reg [NPIN-1:0] pin_s2_r;

  assign pin_raw = {WRITE_CLK_I, READ_CLK_I, WRITE_EN_N_I, READ_EN_N_I,
                    FULL_RESET_N_I, POINTER_ONLY_RESET_N_I,
                    DEFAULT_OFFSET_SELECT0_I, DEFAULT_OFFSET_SELECT1_I,
                    OFFSET_LOAD_N_I, SERIAL_SHIFT_ENABLE_N_I, SERIAL_IN_I,
                    WRITE_DATA_IN_I};

  always @(posedge CLK_I) begin
    if (SRST_I) begin
      pin_s1_r <= PIN_IDLE;
      pin_s2_r <= PIN_IDLE;
    end else begin
      pin_s1_r <= pin_raw;
      pin_s2_r <= pin_s1_r;
    end
  end

  reg mode_pin_s1_r;
  reg mode_pin_s2_r;
  always @(posedge CLK_I) begin
    if (SRST_I) begin
      mode_pin_s1_r <= 1'b0;
      mode_pin_s2_r <= 1'b0;
    end else begin
      mode_pin_s1_r <= FLAG_TIMING_MODE_SELECT_I;
      mode_pin_s2_r <= mode_pin_s1_r;
    end
  end

  wire wclk_s = pin_s2_r[WIDTH+10];
  wire rclk_s = pin_s2_r[WIDTH+9];
  wire wen_n_s = pin_s2_r[WIDTH+8];
  wire ren_n_s = pin_s2_r[WIDTH+7];
  wire frst_n_s = pin_s2_r[WIDTH+6];
  wire prst_n_s = pin_s2_r[WIDTH+5];
  wire sel0_s = pin_s2_r[WIDTH+4];
  wire sel1_s = pin_s2_r[WIDTH+3];
  wire ld_n_s = pin_s2_r[WIDTH+2];
  wire sen_n_s = pin_s2_r[WIDTH+1];
  wire si_s = pin_s2_r[WIDTH];
  wire [WIDTH-1:0] wdata_s = pin_s2_r[WIDTH-1:0];

  // Edge finding on both port clocks
  reg wclk_d_r;
  reg rclk_d_r;
  wire wr_edge;
  wire rd_edge;
  always @(posedge CLK_I) begin
    if (SRST_I) begin
      wclk_d_r <= 1'b0;
      rclk_d_r <= 1'b0;
    end else begin
      wclk_d_r <= wclk_s;
      rclk_d_r <= rclk_s;
    end
  end
  assign wr_edge = wclk_s & ~wclk_d_r;
  assign rd_edge = rclk_s & ~rclk_d_r;

  wire frst = ~frst_n_s;
  wire ptr_clr = frst | ~prst_n_s;

  // Offsets and timing mode
  reg [AW-1:0] pae_off_r;
  reg [AW-1:0] paf_off_r;
  reg mode_r;
  always @(posedge CLK_I) begin
    if (SRST_I) begin
      pae_off_r <= default_offset(3'h0);
      paf_off_r <= default_offset(3'h0);
      mode_r <= `DCFPF_MODE_ASYNC;
    end else if (frst) begin
      pae_off_r <= default_offset({ld_n_s, sel1_s, sel0_s});
      paf_off_r <= default_offset({ld_n_s, sel1_s, sel0_s});
      mode_r <= mode_pin_s2_r;
    end else if (wr_edge & ~ld_n_s & ~sen_n_s) begin
      {paf_off_r, pae_off_r} <= {si_s, paf_off_r, pae_off_r[AW-1:1]};
    end
  end

  // Main array and pointers
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0] wptr_r;
  reg [AW:0] rptr_r;
  reg [AW:0] wgray_r;
  reg [AW:0] rgray_r;
  reg [AW:0] wg_s1_r;
  reg [AW:0] wg_s2_r;
  reg [AW:0] rg_s1_r;
  reg [AW:0] rg_s2_r;
  reg [WIDTH-1:0] rdata_r;

  wire [AW:0] wptr_rd = gray2bin(wg_s2_r);
  wire [AW:0] rptr_wr = gray2bin(rg_s2_r);
  wire [AW:0] rcount = wptr_rd - rptr_r;
  wire [AW:0] wcount = wptr_r - rptr_wr;
  wire [AW:0] true_main = wptr_r - rptr_r;

  wire st_in_ready;
  wire st_out_valid;
  wire [WIDTH-1:0] st_out_data;
  wire [SAW:0] st_count;

  wire [AW+1:0] wtotal = {1'b0, wcount} + {{(AW+1-SAW){1'b0}}, st_count};
  wire [AW+1:0] ttotal = {1'b0, true_main} +
                         {{(AW+1-SAW){1'b0}}, st_count};
  wire empty_w = (rcount == {(AW+1){1'b0}});
  wire full_w = (wtotal >= DEPTH_W);
  wire main_full = (wcount == DEPTH_W[AW:0]);
  wire wr_take = wr_edge & ~wen_n_s & ~full_w & ~ptr_clr &
                 st_in_ready;
  wire rd_take = rd_edge & ~ren_n_s & ~empty_w & ~ptr_clr;
  wire drain = st_out_valid & ~main_full & ~ptr_clr;

  dcfpf_stage_fifo #(
    .WIDTH(WIDTH),
    .DEPTH(`DCFPF_STAGE_DEPTH),
    .AW(SAW)
  ) u_stage (
    .clk_i(CLK_I),
    .rst_i(SRST_I),
    .clr_i(ptr_clr),
    .in_valid_i(wr_take),
    .in_ready_o(st_in_ready),
    .in_data_i(wdata_s),
    .out_valid_o(st_out_valid),
    .out_ready_i(drain),
    .out_data_o(st_out_data),
    .count_o(st_count)
  );

  always @(posedge CLK_I) begin
    if (drain) begin
      mem[wptr_r[AW-1:0]] <= st_out_data;
    end
  end

  always @(posedge CLK_I) begin
    if (SRST_I | ptr_clr) begin
      wptr_r <= {(AW+1){1'b0}};
      rptr_r <= {(AW+1){1'b0}};
      wgray_r <= {(AW+1){1'b0}};
      rgray_r <= {(AW+1){1'b0}};
      wg_s1_r <= {(AW+1){1'b0}};
      wg_s2_r <= {(AW+1){1'b0}};
      rg_s1_r <= {(AW+1){1'b0}};
      rg_s2_r <= {(AW+1){1'b0}};
    end else begin
      if (drain) begin
        wptr_r <= wptr_r + 1'b1;
      end
      if (rd_take) begin
        rptr_r <= rptr_r + 1'b1;
      end
      wgray_r <= bin2gray(wptr_r);
      rgray_r <= bin2gray(rptr_r);
      wg_s1_r <= wgray_r;
      wg_s2_r <= wg_s1_r;
      rg_s1_r <= rgray_r;
      rg_s2_r <= rg_s1_r;
    end
  end

  always @(posedge CLK_I) begin
    if (SRST_I) begin
      rdata_r <= {WIDTH{1'b0}};
    end else if (rd_take) begin
      rdata_r <= mem[rptr_r[AW-1:0]];
    end
  end

  // Flags: empty, full and half every cycle, almost flags one cycle after the port edge
  reg wr_edge_d_r;
  reg rd_edge_d_r;
  reg ef_n_r;
  reg ff_n_r;
  reg hf_n_r;
  reg pae_n_r;
  reg paf_n_r;
  wire [AW+1:0] pae_lim = {2'b00, pae_off_r};
  wire [AW+1:0] paf_lim = DEPTH_W - {2'b00, paf_off_r};

  always @(posedge CLK_I) begin
    if (SRST_I) begin
      wr_edge_d_r <= 1'b0;
      rd_edge_d_r <= 1'b0;
    end else begin
      wr_edge_d_r <= wr_edge;
      rd_edge_d_r <= rd_edge;
    end
  end

  always @(posedge CLK_I) begin
    if (SRST_I | ptr_clr) begin
      ef_n_r <= 1'b0;
      ff_n_r <= 1'b1;
      hf_n_r <= 1'b1;
      pae_n_r <= 1'b0;
      paf_n_r <= 1'b1;
    end else begin
      ef_n_r <= ~empty_w;
      ff_n_r <= ~full_w;
      hf_n_r <= ~(wtotal >= HALF_W);
      if (mode_r == `DCFPF_MODE_SYNC) begin
        if (rd_edge_d_r) begin
          pae_n_r <= ~({1'b0, rcount} <= pae_lim);
        end
        if (wr_edge_d_r) begin
          paf_n_r <= ~(wtotal >= paf_lim);
        end
      end else begin
        if (rd_edge_d_r & (ttotal <= pae_lim)) begin
          pae_n_r <= 1'b0;
        end else if (wr_edge_d_r & (ttotal > pae_lim)) begin
          pae_n_r <= 1'b1;
        end
        if (wr_edge_d_r & (ttotal >= paf_lim)) begin
          paf_n_r <= 1'b0;
        end else if (rd_edge_d_r & (ttotal < paf_lim)) begin
          paf_n_r <= 1'b1;
        end
      end
    end
  end

  // Idle while no control input is active and nothing is moving
  reg idle_r;
  wire ctrl_active = ~wen_n_s | ~ren_n_s | ptr_clr | ~ld_n_s | ~sen_n_s;
  always @(posedge CLK_I) begin
    if (SRST_I) begin
      idle_r <= 1'b0;
    end else begin
      idle_r <= ~ctrl_active & ~st_out_valid;
    end
  end

  assign READ_DATA_OUT_O = rdata_r;
  assign EMPTY_FLAG_N_O = ef_n_r;
  assign FULL_FLAG_N_O = ff_n_r;
  assign HALF_FULL_FLAG_N_O = hf_n_r;
  assign ALMOST_EMPTY_FLAG_N_O = pae_n_r;
  assign ALMOST_FULL_FLAG_N_O = paf_n_r;
  assign IDLE_O = idle_r & ~ctrl_active;

endmodule // dcfpf_top

// file: tb/dcfpf_link_model.sv
`timescale 1ns/1ps
module dcfpf_link_model (
  input wire run_w_i,
  input wire run_r_i,
  output logic wclk_o,
  output logic rclk_o
);
  // Port clocks, unrelated phase, parked low when stopped
  initial begin
    wclk_o = 1'b0;
    // Offset keeps write clock edges off the system clock edges
    #1;
    forever #62.5 wclk_o = run_w_i ? ~wclk_o : 1'b0;
  end
  initial begin
    rclk_o = 1'b0;
    #17;
    forever #62.5 rclk_o = run_r_i ? ~rclk_o : 1'b0;
  end
endmodule // dcfpf_link_model

// file: tb/dcfpf_top_asserts.sv
`timescale 1ns/1ps
module dcfpf_chk (
  input wire CLK_I,
  input wire SRST_I,
  input wire WRITE_CLK_I,
  input wire READ_CLK_I,
  input wire WRITE_EN_N_I,
  input wire FULL_RESET_N_I,
  input wire POINTER_ONLY_RESET_N_I,
  input wire FLAG_TIMING_MODE_SELECT_I,
  input wire EMPTY_FLAG_N_O,
  input wire FULL_FLAG_N_O,
  input wire HALF_FULL_FLAG_N_O,
  input wire ALMOST_EMPTY_FLAG_N_O,
  input wire ALMOST_FULL_FLAG_N_O,
  input wire IDLE_O
);
  logic mode_r, rclk_r, wclk_r;
  logic [7:0] rd_age_r, wr_age_r, q_age_r;
  always_ff @(posedge CLK_I) begin
    rclk_r <= READ_CLK_I;
    wclk_r <= WRITE_CLK_I;
    if (SRST_I) begin
      mode_r <= 1'b0;
      rd_age_r <= 8'h00;
      wr_age_r <= 8'h00;
      q_age_r <= 8'h00;
    end else begin
      if (!FULL_RESET_N_I) mode_r <= FLAG_TIMING_MODE_SELECT_I;
      rd_age_r <= (READ_CLK_I && !rclk_r) ? 8'h00 : rd_age_r + (rd_age_r != 8'hFF);
      wr_age_r <= (WRITE_CLK_I && !wclk_r) ? 8'h00 : wr_age_r + (wr_age_r != 8'hFF);
      if (!FULL_RESET_N_I || !POINTER_ONLY_RESET_N_I) q_age_r <= 8'h00;
      else if (q_age_r != 8'hFF) q_age_r <= q_age_r + 8'h01;
    end
  end
  default clocking @(posedge CLK_I); endclocking
  default disable iff (SRST_I);
  AST_FULL_NOT_EMPTY:
    assert property (!FULL_FLAG_N_O |-> EMPTY_FLAG_N_O) else $error("full and empty");
  AST_FULL_HALF:
    assert property (!FULL_FLAG_N_O |-> !HALF_FULL_FLAG_N_O) else $error("full not half");
  AST_MRES_FLAGS:
    assert property (!FULL_RESET_N_I [*4] ##1 FULL_RESET_N_I |-> !EMPTY_FLAG_N_O
      && FULL_FLAG_N_O && HALF_FULL_FLAG_N_O) else $error("full reset flags");
  AST_PRES_FLAGS:
    assert property (!POINTER_ONLY_RESET_N_I [*4] ##1 POINTER_ONLY_RESET_N_I
      |-> !EMPTY_FLAG_N_O && FULL_FLAG_N_O) else $error("pointer reset flags");
  AST_IDLE_WAKE:
    assert property ($fell(WRITE_EN_N_I) |-> ##[1:3] !IDLE_O) else $error("no wake");
  AST_AE_SYNC:
    assert property (mode_r && q_age_r > 20 && !$stable(ALMOST_EMPTY_FLAG_N_O)
      |-> rd_age_r <= 12) else $error("almost-empty off read edge");
  AST_AF_SYNC:
    assert property (mode_r && q_age_r > 20 && !$stable(ALMOST_FULL_FLAG_N_O)
      |-> wr_age_r <= 12) else $error("almost-full off write edge");
  AST_AE_ASYNC_FALL:
    assert property (!mode_r && q_age_r > 20 && $fell(ALMOST_EMPTY_FLAG_N_O)
      |-> rd_age_r <= 12) else $error("almost-empty fell off read edge");
  cover property (!FULL_FLAG_N_O);
  cover property (mode_r && $rose(ALMOST_EMPTY_FLAG_N_O));
  cover property ($fell(IDLE_O));
endmodule // dcfpf_chk

// file: tb/dcfpf_top_tb_top.sv
`timescale 1ns/1ps
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin mismatches++; \
  $display("[ERR] %s exp %h got %h", n, e, s); end end
module dcfpf_top_tb_top;
  logic CLK_I = 0, SRST_I = 1, WRITE_EN_N_I = 1, READ_EN_N_I = 1, SERIAL_IN_I = 0;
  logic FULL_RESET_N_I = 1, POINTER_ONLY_RESET_N_I = 1, OFFSET_LOAD_N_I = 1;
  logic DEFAULT_OFFSET_SELECT0_I = 0, DEFAULT_OFFSET_SELECT1_I = 0;
  logic SERIAL_SHIFT_ENABLE_N_I = 1, FLAG_TIMING_MODE_SELECT_I = 0;
  logic [15:0] WRITE_DATA_IN_I = 16'h0000, exp_d, rd_exp;
  wire [15:0] READ_DATA_OUT_O;
  wire WRITE_CLK_I, READ_CLK_I, EMPTY_FLAG_N_O, FULL_FLAG_N_O, IDLE_O;
  wire HALF_FULL_FLAG_N_O, ALMOST_EMPTY_FLAG_N_O, ALMOST_FULL_FLAG_N_O;
  wire [4:0] flg = {EMPTY_FLAG_N_O, FULL_FLAG_N_O, HALF_FULL_FLAG_N_O,
    ALMOST_EMPTY_FLAG_N_O, ALMOST_FULL_FLAG_N_O};
  logic run_w = 1, run_r = 1;
  logic [15:0] exp_q[$];
  integer seed = 32'h43F2, mismatches = 0, check_count = 0, cyc = 0, i, k;
  dcfpf_top #(.DEPTH(64), .AW(6)) dut_u (.*);
  dcfpf_link_model link_u (.run_w_i(run_w), .run_r_i(run_r),
    .wclk_o(WRITE_CLK_I), .rclk_o(READ_CLK_I));
  initial forever #2.5 CLK_I = ~CLK_I;
  task automatic wt(input integer n);
    repeat (n) @(posedge CLK_I);
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task wr(input integer n, input bit keep);
    repeat (n) begin
      @(negedge WRITE_CLK_I);
      @(posedge CLK_I);
      exp_d = $random(seed);
      WRITE_EN_N_I <= 1'b0;
      WRITE_DATA_IN_I <= exp_d;
      if (keep) exp_q.push_back(exp_d);
    end
    @(negedge WRITE_CLK_I);
    @(posedge CLK_I);
    WRITE_EN_N_I <= 1'b1;
    wt(30);
  endtask
  task rd(input integer n);
    repeat (n) begin
      @(negedge READ_CLK_I);
      @(posedge CLK_I);
      READ_EN_N_I <= 1'b0;
    end
    @(negedge READ_CLK_I);
    @(posedge CLK_I);
    READ_EN_N_I <= 1'b1;
    wt(30);
  endtask
  task ser(input [11:0] v);
    OFFSET_LOAD_N_I <= 1'b0;
    for (k = 0; k < 12; k++) begin
      @(negedge WRITE_CLK_I);
      @(posedge CLK_I);
      SERIAL_SHIFT_ENABLE_N_I <= 1'b0;
      SERIAL_IN_I <= v[k];
    end
    @(negedge WRITE_CLK_I);
    @(posedge CLK_I);
    SERIAL_SHIFT_ENABLE_N_I <= 1'b1;
    OFFSET_LOAD_N_I <= 1'b1;
  endtask
  task mrst(input [2:0] idx, input bit mode);
    @(posedge CLK_I);
    {OFFSET_LOAD_N_I, DEFAULT_OFFSET_SELECT1_I, DEFAULT_OFFSET_SELECT0_I} <= idx;
    FLAG_TIMING_MODE_SELECT_I <= mode;
    FULL_RESET_N_I <= 1'b0;
    wt(6);
    FULL_RESET_N_I <= 1'b1;
    wt(6);
    OFFSET_LOAD_N_I <= 1'b1;
    wt(4);
    exp_q.delete();
  endtask
  task prst;
    @(posedge CLK_I);
    POINTER_ONLY_RESET_N_I <= 1'b0;
    wt(6);
    POINTER_ONLY_RESET_N_I <= 1'b1;
    wt(6);
    exp_q.delete();
  endtask
  always @(posedge READ_CLK_I)
    if (READ_EN_N_I === 1'b0 && EMPTY_FLAG_N_O === 1'b1) begin
      rd_exp = exp_q.pop_front();
      wt(6);
      `CHK("rdata", rd_exp, READ_DATA_OUT_O)
    end
  always @(posedge CLK_I) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      mismatches++;
      end_sim;
    end
  end
  initial begin
    wt(2);
    SRST_I <= 1'b0;
    mrst(0, 0);
    `CHK("flags", 5'b01101, flg)
    wt(2);
    `CHK("idle", 1'b1, IDLE_O)
    for (i = 0; i < 8; i++) begin
      mrst(i, 0);
      k = ((8 << i) - 1 < 63) ? (8 << i) - 1 : 63;
      wr(k, 0);
      `CHK("ae", 1'b0, flg[1])
      if (k < 63) begin
        wr(1, 0);
        `CHK("ae", 1'b1, flg[1])
      end
    end
    mrst(0, 0);
    wr(32, 1);
    `CHK("hf", 1'b1, flg[2])
    wr(1, 1);
    `CHK("hf", 1'b0, flg[2])
    wr(23, 1);
    `CHK("af", 1'b1, flg[0])
    wr(1, 1);
    `CHK("af", 1'b0, flg[0])
    wr(7, 1);
    `CHK("ff", 1'b0, flg[3])
    wr(1, 0);
    rd(8);
    `CHK("af", 1'b1, flg[0])
    rd(57);
    `CHK("ef", 1'b0, flg[4])
    wr(1, 1);
    rd(1);
    ser({6'd5, 6'd3});
    prst;
    wr(3, 0);
    `CHK("ae", 1'b0, flg[1])
    wr(1, 0);
    `CHK("ae", 1'b1, flg[1])
    wr(54, 0);
    `CHK("af", 1'b1, flg[0])
    wr(1, 0);
    `CHK("af", 1'b0, flg[0])
    mrst(0, 1);
    run_r <= 1'b0;
    wr(8, 1);
    `CHK("ae", 1'b0, flg[1])
    run_r <= 1'b1;
    wt(100);
    `CHK("ae", 1'b1, flg[1])
    wr(49, 1);
    `CHK("af", 1'b0, flg[0])
    run_w <= 1'b0;
    rd(1);
    `CHK("af", 1'b0, flg[0])
    run_w <= 1'b1;
    wt(100);
    `CHK("af", 1'b1, flg[0])
    end_sim;
  end
endmodule // dcfpf_top_tb_top
bind dcfpf_top dcfpf_chk chk_u (.*);
